//--- rtl/led_sink_pkg.sv
// Purpose: Shared constants and types for the LED sink control registers
// Assumes: 20 MHz core clock, 8-bit register addresses and data
// Notes:   Every offset, field and timing figure used by the design lives here
package led_sink_pkg;

    // ==========================================================================
    // Bus and register map
    // ==========================================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] DARK_DIM_CURRENT_ADDR      = 8'h0e;
    localparam logic [ADDR_W-1:0] SINK_FADE_LAW_ADDR         = 8'h0f;
    localparam logic [ADDR_W-1:0] SINK_ENABLE_CONTROL_ADDR   = 8'h10;
    localparam logic [ADDR_W-1:0] SINK_BLINK_TIME_UPPER_ADDR = 8'h11;
    localparam logic [ADDR_W-1:0] DIM_CONTROL_ADDR           = 8'h20;
    localparam logic [ADDR_W-1:0] SINK_STATUS_ADDR           = 8'h21;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // ==========================================================================
    // Field layout
    // ==========================================================================
    localparam int unsigned DIM_CODE_W   = 7;
    localparam int unsigned LAW_W        = 2;
    localparam int unsigned NUM_SINKS    = 7;
    localparam int unsigned TIME_CODE_W  = 2;
    localparam int unsigned ON_TIME_LSB  = 6;
    localparam int unsigned SINK7_OFF_LSB = 4;
    localparam int unsigned SINK6_OFF_LSB = 2;
    localparam int unsigned SINK5_OFF_LSB = 0;
    localparam int unsigned DIM_EN_BIT   = 0;
    localparam int unsigned FIRST_UPPER_SINK = 4;

    // Masks that keep reserved bits at zero
    localparam logic [DATA_W-1:0] DIM_CODE_MASK = 8'h7f;
    localparam logic [DATA_W-1:0] LAW_MASK      = 8'h03;
    localparam logic [DATA_W-1:0] ENABLE_MASK   = 8'h7f;
    localparam logic [DATA_W-1:0] DIM_CTRL_MASK = 8'h01;

    // ==========================================================================
    // Fade law encoding
    // ==========================================================================
    localparam logic [LAW_W-1:0] LAW_LINEAR_LINEAR = 2'h0;
    localparam logic [LAW_W-1:0] LAW_SQUARE_LINEAR = 2'h1;
    localparam logic [LAW_W-1:0] LAW_SQUARE_CUBIC0 = 2'h2;
    localparam logic [LAW_W-1:0] LAW_SQUARE_CUBIC1 = 2'h3;

    typedef struct packed {
        logic square_dac;
        logic nonlinear_steps;
        logic cubic_profile;
    } fade_ctrl_t;

    // ==========================================================================
    // DAC scale: linear step 0.236 mA, full code gives 30 mA
    // ==========================================================================
    localparam int unsigned CURRENT_UA_W    = 15;
    localparam logic [CURRENT_UA_W-1:0] LIN_STEP_UA   = 15'h00ec;
    localparam logic [CURRENT_UA_W-1:0] FULL_SCALE_UA = 15'h7530;
    localparam logic [DIM_CODE_W-1:0]   FULL_CODE     = 7'h7f;

    // ==========================================================================
    // Blink timing, in steps of 0.2 s
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned BLINK_STEP_MS = 200;
    localparam int unsigned BLINK_STEP_CYCLES = (BLINK_STEP_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CNT_W = 22;
    localparam int unsigned PHASE_W    = 4;

    localparam logic [TIME_CODE_W-1:0] OFF_DISABLED = 2'h0;

    // On: 0.2, 0.6, 0.8, 1.2 s ; Off: -, 0.6, 1.2, 1.8 s
    localparam logic [PHASE_W-1:0] ON_STEPS_0  = 4'h1;
    localparam logic [PHASE_W-1:0] ON_STEPS_1  = 4'h3;
    localparam logic [PHASE_W-1:0] ON_STEPS_2  = 4'h4;
    localparam logic [PHASE_W-1:0] ON_STEPS_3  = 4'h6;
    localparam logic [PHASE_W-1:0] OFF_STEPS_1 = 4'h3;
    localparam logic [PHASE_W-1:0] OFF_STEPS_2 = 4'h6;
    localparam logic [PHASE_W-1:0] OFF_STEPS_3 = 4'h9;

    typedef enum logic { BLINK_ON, BLINK_OFF } blink_state_t;

endpackage : led_sink_pkg

//--- rtl/sink_blinker.sv
// Purpose: On/off blink sequencer for one current sink
// Assumes: Codes are stable register outputs on the same clock
// Notes:   Sequence restarts in the on phase whenever the sink is enabled
module sink_blinker #(
    parameter int unsigned STEP_CYCLES = led_sink_pkg::BLINK_STEP_CYCLES
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst_n,
    input  wire logic                                  enable,
    input  wire logic [led_sink_pkg::TIME_CODE_W-1:0]  on_code,
    input  wire logic [led_sink_pkg::TIME_CODE_W-1:0]  off_code,
    output      logic                                  sink_active
);

    localparam logic [led_sink_pkg::STEP_CNT_W-1:0] STEP_LAST =
        led_sink_pkg::STEP_CNT_W'(STEP_CYCLES - 1);

    led_sink_pkg::blink_state_t              state_reg;
    logic [led_sink_pkg::STEP_CNT_W-1:0]     pre_reg;
    logic [led_sink_pkg::PHASE_W-1:0]        steps_reg;
    logic [led_sink_pkg::PHASE_W-1:0]        on_steps;
    logic [led_sink_pkg::PHASE_W-1:0]        off_steps;
    logic                                    step_tick;
    logic                                    steady;

    always_comb begin
        unique case (on_code)
            2'h0:    on_steps = led_sink_pkg::ON_STEPS_0;
            2'h1:    on_steps = led_sink_pkg::ON_STEPS_1;
            2'h2:    on_steps = led_sink_pkg::ON_STEPS_2;
            2'h3:    on_steps = led_sink_pkg::ON_STEPS_3;
        endcase
    end

    always_comb begin
        unique case (off_code)
            2'h0:    off_steps = led_sink_pkg::OFF_STEPS_1;
            2'h1:    off_steps = led_sink_pkg::OFF_STEPS_1;
            2'h2:    off_steps = led_sink_pkg::OFF_STEPS_2;
            2'h3:    off_steps = led_sink_pkg::OFF_STEPS_3;
        endcase
    end

    assign steady    = (off_code == led_sink_pkg::OFF_DISABLED);
    assign step_tick = (pre_reg == STEP_LAST);

    // ==========================================================================
    // Step prescaler, held at zero while disabled so sinks start in step
    // ==========================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
        end else if (!enable || step_tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // ==========================================================================
    // Phase sequencer
    // ==========================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= led_sink_pkg::BLINK_ON;
            steps_reg <= '0;
        end else if (!enable || steady) begin
            state_reg <= led_sink_pkg::BLINK_ON;
            steps_reg <= '0;
        end else if (step_tick) begin
            unique case (state_reg)
                led_sink_pkg::BLINK_ON: begin
                    if (steps_reg + 1'b1 >= on_steps) begin
                        state_reg <= led_sink_pkg::BLINK_OFF;
                        steps_reg <= '0;
                    end else begin
                        steps_reg <= steps_reg + 1'b1;
                    end
                end
                led_sink_pkg::BLINK_OFF: begin
                    if (steps_reg + 1'b1 >= off_steps) begin
                        state_reg <= led_sink_pkg::BLINK_ON;
                        steps_reg <= '0;
                    end else begin
                        steps_reg <= steps_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_active <= 1'b0;
        end else begin
            sink_active <= enable && (steady || (state_reg == led_sink_pkg::BLINK_ON));
        end
    end

endmodule : sink_blinker

//--- rtl/dim_level_select.sv
// Purpose: Chooses the backlight DAC code between normal and dark dim level
// Assumes: Timeout and wake are one-cycle pulses on core_clk
// Notes:   A timeout in the same cycle as a wake keeps the dimmed state
module dim_level_select (
    input  wire logic                                 core_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 dim_timeout,
    input  wire logic                                 wake,
    input  wire logic                                 dim_en,
    input  wire logic [led_sink_pkg::DIM_CODE_W-1:0]  max_code,
    input  wire logic [led_sink_pkg::DIM_CODE_W-1:0]  dim_code,
    output      logic                                 dimmed,
    output      logic [led_sink_pkg::DIM_CODE_W-1:0]  level_code
);

    logic timed_out_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timed_out_reg <= 1'b0;
        end else if (dim_timeout) begin
            timed_out_reg <= 1'b1;
        end else if (wake) begin
            timed_out_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dimmed     <= 1'b0;
            level_code <= '0;
        end else begin
            dimmed     <= timed_out_reg || dim_en;
            level_code <= (timed_out_reg || dim_en) ? dim_code : max_code;
        end
    end

endmodule : dim_level_select

//--- rtl/led_sink_control_regs.sv
// Purpose: Configuration registers for backlight dim level and seven current sinks
// Assumes: Register port on core_clk; timer pulses come from logic on the same clock
// Notes:   Read data appears in the cycle after the read strobe only
//
// The strobed register port was decided locally.

// What this block does
// - Dark dim code held in bits 6:0
// - Dim on timer expiry or dim enable flag
// - Code maps linearly, 0.236 mA per step
// - Two-bit fade law selector, upper bits reserved
// - Codes 00/01 select linear steps, DAC law
// - Codes 10/11 square DAC, own cubic profile
// - Seven enable bits, bit0 is sink one
// - Enable bit one turns sink on
// - On-time code selects 0.2 to 1.2 s
// - Off-time codes for sinks 7,6,5 give pauses
// - Off code 00 keeps sink steadily on
module led_sink_control_regs #(
    parameter int unsigned STEP_CYCLES = led_sink_pkg::BLINK_STEP_CYCLES
) (
    input  wire logic                                     core_clk,
    input  wire logic                                     rst_n,
    input  wire logic [led_sink_pkg::ADDR_W-1:0]          reg_addr,
    input  wire logic [led_sink_pkg::DATA_W-1:0]          reg_wdata,
    input  wire logic                                     reg_write,
    input  wire logic                                     reg_read,
    output      logic [led_sink_pkg::DATA_W-1:0]          reg_rdata,
    input  wire logic                                     dim_timeout,
    input  wire logic                                     wake,
    input  wire logic [led_sink_pkg::DIM_CODE_W-1:0]      backlight_max_code,
    input  wire logic [led_sink_pkg::DATA_W-1:0]          sink_blink_time_lower,
    output      logic [led_sink_pkg::DIM_CODE_W-1:0]      backlight_code,
    output      logic                                     backlight_dimmed,
    output      logic [led_sink_pkg::CURRENT_UA_W-1:0]    backlight_lin_ua,
    output      led_sink_pkg::fade_ctrl_t                 fade_ctrl,
    output      logic [led_sink_pkg::NUM_SINKS-1:0]       sink_drive
);

    // ==========================================================================
    // Register storage
    // ==========================================================================
    logic [led_sink_pkg::DIM_CODE_W-1:0]   dark_dim_code;
    logic [led_sink_pkg::LAW_W-1:0]        fade_law_select;
    logic [led_sink_pkg::NUM_SINKS-1:0]    sink_on;
    logic [led_sink_pkg::DATA_W-1:0]       blink_time_upper_reg;
    logic                                  dim_en_reg;
    logic [led_sink_pkg::NUM_SINKS-1:0]    sink_active;
    logic                                  dimmed_w;
    logic [led_sink_pkg::DIM_CODE_W-1:0]   level_w;
    logic [led_sink_pkg::TIME_CODE_W-1:0]  blink_on_time;
    logic [led_sink_pkg::TIME_CODE_W-1:0]  sink7_off_time;
    logic [led_sink_pkg::TIME_CODE_W-1:0]  sink6_off_time;
    logic [led_sink_pkg::TIME_CODE_W-1:0]  sink5_off_time;
    logic [led_sink_pkg::TIME_CODE_W-1:0]  off_code [led_sink_pkg::NUM_SINKS];
    logic [led_sink_pkg::DATA_W-1:0]       rdata_next;

    logic wr_dim;
    logic wr_law;
    logic wr_en;
    logic wr_time;
    logic wr_dctl;

    assign wr_dim  = reg_write && (reg_addr == led_sink_pkg::DARK_DIM_CURRENT_ADDR);
    assign wr_law  = reg_write && (reg_addr == led_sink_pkg::SINK_FADE_LAW_ADDR);
    assign wr_en   = reg_write && (reg_addr == led_sink_pkg::SINK_ENABLE_CONTROL_ADDR);
    assign wr_time = reg_write && (reg_addr == led_sink_pkg::SINK_BLINK_TIME_UPPER_ADDR);
    assign wr_dctl = reg_write && (reg_addr == led_sink_pkg::DIM_CONTROL_ADDR);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dark_dim_code <= '0;
        end else if (wr_dim) begin
            dark_dim_code <= reg_wdata[led_sink_pkg::DIM_CODE_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fade_law_select <= '0;
        end else if (wr_law) begin
            fade_law_select <= reg_wdata[led_sink_pkg::LAW_W-1:0];
        end
    end

    // All sinks written together start their sequences in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_on <= '0;
        end else if (wr_en) begin
            sink_on <= reg_wdata[led_sink_pkg::NUM_SINKS-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_time_upper_reg <= led_sink_pkg::REG_RESET;
        end else if (wr_time) begin
            blink_time_upper_reg <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dim_en_reg <= 1'b0;
        end else if (wr_dctl) begin
            dim_en_reg <= reg_wdata[led_sink_pkg::DIM_EN_BIT];
        end
    end

    // ==========================================================================
    // Read path: reserved bits and unmapped addresses return zero
    // ==========================================================================
    always_comb begin
        rdata_next = led_sink_pkg::READ_ZERO;
        unique case (reg_addr)
            led_sink_pkg::DARK_DIM_CURRENT_ADDR:
                rdata_next = led_sink_pkg::DATA_W'(dark_dim_code) & led_sink_pkg::DIM_CODE_MASK;
            led_sink_pkg::SINK_FADE_LAW_ADDR:
                rdata_next = led_sink_pkg::DATA_W'(fade_law_select) & led_sink_pkg::LAW_MASK;
            led_sink_pkg::SINK_ENABLE_CONTROL_ADDR:
                rdata_next = led_sink_pkg::DATA_W'(sink_on) & led_sink_pkg::ENABLE_MASK;
            led_sink_pkg::SINK_BLINK_TIME_UPPER_ADDR:
                rdata_next = blink_time_upper_reg;
            led_sink_pkg::DIM_CONTROL_ADDR:
                rdata_next = led_sink_pkg::DATA_W'(dim_en_reg) & led_sink_pkg::DIM_CTRL_MASK;
            led_sink_pkg::SINK_STATUS_ADDR:
                rdata_next = {dimmed_w, sink_active};
            default:
                rdata_next = led_sink_pkg::READ_ZERO;
        endcase
    end

    // Data held only for the one cycle after a read, zero otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= led_sink_pkg::READ_ZERO;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= led_sink_pkg::READ_ZERO;
        end
    end

    // ==========================================================================
    // Backlight dim level
    // ==========================================================================
    dim_level_select u_dim (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .dim_timeout(dim_timeout),
        .wake       (wake),
        .dim_en     (dim_en_reg),
        .max_code   (backlight_max_code),
        .dim_code   (dark_dim_code),
        .dimmed     (dimmed_w),
        .level_code (level_w)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            backlight_code   <= '0;
            backlight_dimmed <= 1'b0;
        end else begin
            backlight_code   <= level_w;
            backlight_dimmed <= dimmed_w;
        end
    end

    // Linear-law current estimate; full code pinned to the exact full scale
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            backlight_lin_ua <= '0;
        end else if (level_w == led_sink_pkg::FULL_CODE) begin
            backlight_lin_ua <= led_sink_pkg::FULL_SCALE_UA;
        end else begin
            backlight_lin_ua <= led_sink_pkg::CURRENT_UA_W'(
                led_sink_pkg::CURRENT_UA_W'(level_w) * led_sink_pkg::LIN_STEP_UA);
        end
    end

    // ==========================================================================
    // Fade law decode
    // ==========================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fade_ctrl <= '0;
        end else begin
            unique case (fade_law_select)
                led_sink_pkg::LAW_LINEAR_LINEAR: fade_ctrl <= 3'b000;
                led_sink_pkg::LAW_SQUARE_LINEAR: fade_ctrl <= 3'b100;
                led_sink_pkg::LAW_SQUARE_CUBIC0: fade_ctrl <= 3'b110;
                led_sink_pkg::LAW_SQUARE_CUBIC1: fade_ctrl <= 3'b111;
            endcase
        end
    end

    // ==========================================================================
    // Blink sequencers, one per sink
    // ==========================================================================
    assign blink_on_time  = blink_time_upper_reg[led_sink_pkg::ON_TIME_LSB +: led_sink_pkg::TIME_CODE_W];
    assign sink7_off_time = blink_time_upper_reg[led_sink_pkg::SINK7_OFF_LSB +: led_sink_pkg::TIME_CODE_W];
    assign sink6_off_time = blink_time_upper_reg[led_sink_pkg::SINK6_OFF_LSB +: led_sink_pkg::TIME_CODE_W];
    assign sink5_off_time = blink_time_upper_reg[led_sink_pkg::SINK5_OFF_LSB +: led_sink_pkg::TIME_CODE_W];

    // Sinks 1 to 4 take their off times from the lower time register outside
    for (genvar i = 0; i < led_sink_pkg::FIRST_UPPER_SINK; i++) begin : g_low
        assign off_code[i] = sink_blink_time_lower[i*led_sink_pkg::TIME_CODE_W +: led_sink_pkg::TIME_CODE_W];
    end
    assign off_code[4] = sink5_off_time;
    assign off_code[5] = sink6_off_time;
    assign off_code[6] = sink7_off_time;

    for (genvar s = 0; s < led_sink_pkg::NUM_SINKS; s++) begin : g_sink
        sink_blinker #(
            .STEP_CYCLES(STEP_CYCLES)
        ) u_blink (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .enable     (sink_on[s]),
            .on_code    (blink_on_time),
            .off_code   (off_code[s]),
            .sink_active(sink_active[s])
        );
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_drive <= '0;
        end else begin
            sink_drive <= sink_active;
        end
    end

endmodule : led_sink_control_regs

//--- bench/led_host_model.sv
// Purpose: Host controller that writes and reads the sink control registers
// Assumes: One-cycle strobes, read data valid in the cycle after the strobe
// Notes:   Strobes change by non-blocking assignment just after a rising edge
module led_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output      logic [7:0] reg_addr,
    output      logic [7:0] reg_wdata,
    output      logic       reg_write,
    output      logic       reg_read
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    end
    // Sinks meant to run together are enabled by one call, one bus cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : led_host_model

//--- bench/led_sink_control_regs_properties.sv
// Purpose: Port-level checks of the sink control register block
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Attached to the design by the bind at the foot of this file
module led_sink_control_regs_properties (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic [7:0]               reg_addr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_write,
    input wire logic                     reg_read,
    input wire logic [7:0]               reg_rdata,
    input wire logic                     dim_timeout,
    input wire logic [6:0]               backlight_code,
    input wire logic                     backlight_dimmed,
    input wire logic [14:0]              backlight_lin_ua,
    input wire led_sink_pkg::fade_ctrl_t fade_ctrl,
    input wire logic [6:0]               sink_drive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Read-back of reserved and unmapped places
    a_dim_rsvd_zero:
    assert property (reg_read && reg_addr == 8'h0e |=> !reg_rdata[7]) else $error("dim bit 7 set");
    a_law_rsvd_zero:
    assert property (reg_read && reg_addr == 8'h0f |=> reg_rdata[7:2] == 6'h00)
        else $error("law upper bits set");
    a_enable_rsvd_zero:
    assert property (reg_read && reg_addr == 8'h10 |=> !reg_rdata[7]) else $error("enable bit 7 set");
    a_unmapped_reads_zero:
    assert property (reg_read && !(reg_addr inside {8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20, 8'h21})
        |=> reg_rdata == 8'h00) else $error("unmapped read nonzero");
    // ==========================================================
    // Outputs versus their causes
    a_law_linear_steps:
    assert property (reg_write && reg_addr == 8'h0f && !reg_wdata[1] ##1 !(reg_write && reg_addr == 8'h0f)
        |=> fade_ctrl == {$past(reg_wdata[0], 2), 2'b00}) else $error("linear step law wrong");
    a_law_cubic_steps:
    assert property (reg_write && reg_addr == 8'h0f && reg_wdata[1] ##1 !(reg_write && reg_addr == 8'h0f)
        |=> fade_ctrl == {2'b11, $past(reg_wdata[0], 2)}) else $error("cubic law wrong");
    a_sink_off_follows:
    assert property (reg_write && reg_addr == 8'h10 ##1 !(reg_write && reg_addr == 8'h10) [*2]
        |=> (sink_drive & ~$past(reg_wdata[6:0], 3)) == 7'h00) else $error("disabled sink driven");
    a_timeout_dims:
    assert property (dim_timeout |=> ##2 backlight_dimmed) else $error("timeout did not dim");
    a_linear_current:
    assert property (backlight_lin_ua == ((backlight_code == 7'h7f) ? 15'h7530
        : 15'(backlight_code) * 15'h00ec)) else $error("linear current wrong");
endmodule : led_sink_control_regs_properties

bind led_sink_control_regs led_sink_control_regs_properties led_sink_control_regs_properties_i (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .dim_timeout,
    .backlight_code, .backlight_dimmed, .backlight_lin_ua, .fade_ctrl, .sink_drive);

//--- bench/tb_led_sink_control_regs.sv
// Purpose: Directed register-level test of the sink control block
// Assumes: Blink step shortened to 4 cycles so sequences run quickly
// Notes:   Normal backlight code and sink 1-4 off times are held constant
module tb_led_sink_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     core_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     dim_timeout = 1'b0;
    logic                     wake = 1'b0;
    logic [7:0]               reg_addr, reg_wdata, reg_rdata, rd_val;
    logic                     reg_write, reg_read, backlight_dimmed;
    logic [6:0]               backlight_code, sink_drive;
    logic [14:0]              backlight_lin_ua;
    led_sink_pkg::fade_ctrl_t fade_ctrl;
    int                       num_errors = 0, n_compared = 0, cycles = 0, ons = 0;
    logic [7:0]               addrs [6] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20, 8'h12};
    logic [7:0]               masks [6] = '{8'h7f, 8'h03, 8'h7f, 8'hff, 8'h01, 8'h00};
    always #25 core_clk = ~core_clk;
    led_host_model led_host_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
    led_sink_control_regs #(.STEP_CYCLES(4)) led_sink_control_regs_i (.core_clk(core_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .dim_timeout(dim_timeout), .wake(wake),
        .backlight_max_code(7'h55), .sink_blink_time_lower(8'h00), .backlight_code(backlight_code),
        .backlight_dimmed(backlight_dimmed), .backlight_lin_ua(backlight_lin_ua),
        .fade_ctrl(fade_ctrl), .sink_drive(sink_drive));
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic wrap_up;
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // Ceiling well above the roughly 190 cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (addrs[i]) begin
            led_host_model_i.rd(addrs[i], rd_val);
            check("reset value", rd_val, 15'h0000);
            led_host_model_i.wr(addrs[i], 8'hff);
            led_host_model_i.rd(addrs[i], rd_val);
            check("read back", rd_val, masks[i]);
            led_host_model_i.wr(addrs[i], 8'h00);
        end
        for (int c = 0; c < 4; c++) begin
            led_host_model_i.wr(8'h0f, {6'h3f, c[1:0]});
            settle(2);
            check("fade law", fade_ctrl, (c == 0) ? 0 : (c == 1) ? 3'b100 : {2'b11, c[0]});
        end
        for (int i = 0; i < 7; i++) begin
            led_host_model_i.wr(8'h10, 8'h80 | (8'h01 << i));
            settle(3);
            check("single sink", sink_drive, 7'h01 << i);
        end
        led_host_model_i.wr(8'h10, 8'h00);
        settle(3);
        check("all off", sink_drive, 15'h0000);
        // Sinks 5 and 6 blink: on one step, off three steps
        led_host_model_i.wr(8'h11, 8'h05);
        led_host_model_i.wr(8'h10, 8'h30);
        settle(2);
        repeat (32) begin
            settle(1);
            ons += sink_drive[4];
            check("lockstep", sink_drive[5], sink_drive[4]);
        end
        check("on cycles", ons, 15'h0008);
        led_host_model_i.wr(8'h0e, 8'h25);
        led_host_model_i.wr(8'h20, 8'h01);
        settle(3);
        check("dim flag code", {backlight_dimmed, backlight_code}, 15'h00a5);
        check("dim current", backlight_lin_ua, 15'h221c);
        led_host_model_i.wr(8'h20, 8'h00);
        settle(3);
        check("undimmed", {backlight_dimmed, backlight_code}, 15'h0055);
        @(posedge core_clk) dim_timeout <= 1'b1;
        @(posedge core_clk) dim_timeout <= 1'b0;
        settle(3);
        check("timeout dim", {backlight_dimmed, backlight_code}, 15'h00a5);
        @(posedge core_clk) wake <= 1'b1;
        @(posedge core_clk) wake <= 1'b0;
        settle(3);
        check("woken", {backlight_dimmed, backlight_code}, 15'h0055);
        wrap_up();
    end
endmodule : tb_led_sink_control_regs
